//--- rtl/clock_gate_pkg.sv
package clock_gate_pkg;

    // register byte addresses on the bus
    localparam int          ADDR_WIDTH        = 12;
    localparam logic [11:0] DEEP_GATE_OFFSET  = 12'h124;
    localparam logic [11:0] RUN_GATE_OFFSET   = 12'h200;
    localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h204;
    localparam logic [11:0] RUN_CONFIG_OFFSET = 12'h208;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h20C;
    localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h210;

    // enable bit positions, shared by run, sleep and deep-sleep layouts
    localparam int COMPARATOR1_CLOCK_GATE_BIT  = 25;
    localparam int COMPARATOR0_CLOCK_GATE_BIT  = 24;
    localparam int GP_COUNTER3_CLOCK_GATE_BIT  = 19;
    localparam int GP_COUNTER2_CLOCK_GATE_BIT  = 18;
    localparam int GP_COUNTER1_CLOCK_GATE_BIT  = 17;
    localparam int GP_COUNTER0_CLOCK_GATE_BIT  = 16;
    localparam int TWO_WIRE1_CLOCK_GATE_BIT    = 14;
    localparam int TWO_WIRE0_CLOCK_GATE_BIT    = 12;
    localparam int SYNC_SERIAL1_CLOCK_GATE_BIT = 5;
    localparam int SYNC_SERIAL0_CLOCK_GATE_BIT = 4;
    localparam int ASYNC_SERIAL2_CLOCK_GATE_BIT = 2;
    localparam int ASYNC_SERIAL1_CLOCK_GATE_BIT = 1;
    localparam int ASYNC_SERIAL0_CLOCK_GATE_BIT = 0;

    // writable enable bits; every other position is reserved
    localparam logic [31:0] GATE_WRITE_MASK =
        (32'h1 << COMPARATOR1_CLOCK_GATE_BIT) | (32'h1 << COMPARATOR0_CLOCK_GATE_BIT) |
        (32'h1 << GP_COUNTER3_CLOCK_GATE_BIT) | (32'h1 << GP_COUNTER2_CLOCK_GATE_BIT) |
        (32'h1 << GP_COUNTER1_CLOCK_GATE_BIT) | (32'h1 << GP_COUNTER0_CLOCK_GATE_BIT) |
        (32'h1 << TWO_WIRE1_CLOCK_GATE_BIT) | (32'h1 << TWO_WIRE0_CLOCK_GATE_BIT) |
        (32'h1 << SYNC_SERIAL1_CLOCK_GATE_BIT) | (32'h1 << SYNC_SERIAL0_CLOCK_GATE_BIT) |
        (32'h1 << ASYNC_SERIAL2_CLOCK_GATE_BIT) | (32'h1 << ASYNC_SERIAL1_CLOCK_GATE_BIT) |
        (32'h1 << ASYNC_SERIAL0_CLOCK_GATE_BIT);
    localparam logic [31:0] GATE_RESET        = 32'h0000_0000;

    // run clock configuration fields
    localparam int          AUTO_CLOCK_GATING_BIT = 0;
    localparam logic [31:0] CONFIG_WRITE_MASK     = 32'h1 << AUTO_CLOCK_GATING_BIT;
    localparam logic [31:0] CONFIG_RESET          = 32'h0000_0000;

    // interrupt status and mask fields
    localparam int          IRQ_FAULT_BIT      = 0;
    localparam int          IRQ_DEEP_ENTRY_BIT = 1;
    localparam logic [31:0] IRQ_WRITE_MASK     = (32'h1 << IRQ_FAULT_BIT) |
                                                 (32'h1 << IRQ_DEEP_ENTRY_BIT);
    localparam logic [31:0] IRQ_RESET          = 32'h0000_0000;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERROR = 2'h3;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_type;

    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP  = 2'b11
    } power_mode_type;

    // expand byte enables to a bit mask
    function automatic logic [31:0] byte_mask(input logic [3:0] be);
        byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : byte_mask

    // merge write data into the writable, enabled bits only
    function automatic logic [31:0] merge_write(input logic [31:0] old,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  be,
                                                input logic [31:0] wmask);
        logic [31:0] m;
        m           = byte_mask(be) & wmask;
        merge_write = (old & ~m) | (wdata & m);
    endfunction : merge_write

endpackage : clock_gate_pkg

//--- rtl/gate_select.sv
`timescale 1ns/1ps
`default_nettype none
module gate_select (
    input  wire clock_gate_pkg::power_mode_type power_mode,
    input  wire logic                           auto_gating,
    input  wire logic [31:0]                    run_gate,
    input  wire logic [31:0]                    sleep_gate,
    input  wire logic [31:0]                    deep_gate,
    output logic [31:0]                         selected,
    output logic                                deep_active
);
    import clock_gate_pkg::*;

    // pick the enable set for the present power mode
    always_comb begin
        selected    = run_gate;
        deep_active = 1'b0;
        if (auto_gating) begin
            case (power_mode)
                MODE_SLEEP: begin
                    selected = sleep_gate;
                end
                MODE_DEEP: begin
                    selected    = deep_gate;
                    deep_active = 1'b1;
                end
                default: begin
                    selected = run_gate;
                end
            endcase
        end
    end

endmodule : gate_select
`default_nettype wire

//--- rtl/deep_sleep_clock_gating_reg1.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - set bit clocks its unit, clear disables
// - access to gated unit answers bus fault
// - all enable registers reset to zero
// - deep-sleep enables apply only in deep-sleep with auto gating
// - sleep sets need auto gating, else run
// - bits 25,24 gate comparators 1 and 0
// - bits 19..16 gate counters 3..0
// - bits 14,12 gate two-wire units 1,0
// - bits 5,4 gate sync serial 1,0
// - bits 2..0 gate async serial 2..0
// - reserved bits read-only, read as zero
module deep_sleep_clock_gating_reg1 (
    input  wire logic                             mclk,
    input  wire logic                             rst,
    // avalon-mm register slave
    input  wire logic [clock_gate_pkg::ADDR_WIDTH-1:0] avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [31:0]                      avs_writedata,
    input  wire logic [3:0]                       avs_byteenable,
    output logic [31:0]                           avs_readdata,
    output logic                                  avs_waitrequest,
    output logic [1:0]                            avs_response,
    // power-mode controller
    input  wire clock_gate_pkg::power_mode_type   power_mode,
    // gated peripheral side
    output logic [31:0]                           clock_enable,
    input  wire logic                             periph_req,
    input  wire logic [4:0]                       periph_unit,
    output logic                                  periph_grant,
    output logic                                  periph_fault,
    output logic                                  irq
);
    import clock_gate_pkg::*;

    logic [31:0]   run_clock_gate_1;
    logic [31:0]   sleep_clock_gate_1;
    logic [31:0]   deep_sleep_clock_gate_1;
    logic [31:0]   run_clock_config;
    logic [31:0]   irq_status;
    logic [31:0]   irq_mask;
    bus_state_type bus_state;
    bus_state_type next_state;
    logic [31:0]   read_value;
    logic          addr_hit;
    logic          wr_commit;
    logic          auto_clock_gating;
    logic [31:0]   selected;
    logic          deep_active;
    logic          deep_active_q;
    logic          fault_event;
    logic          deep_entry;
    logic [31:0]   irq_set;
    logic [31:0]   irq_clear;

    // a write lands at the edge where waitrequest is low
    assign wr_commit         = (bus_state == BUS_ACK) && avs_write;
    assign auto_clock_gating = run_clock_config[AUTO_CLOCK_GATING_BIT];

    // bus handshake state
    always_comb begin
        case (bus_state)
            BUS_IDLE: begin
                next_state = (avs_read || avs_write) ? BUS_ACK : BUS_IDLE;
            end
            BUS_ACK: begin
                next_state = BUS_IDLE;
            end
            default: begin
                next_state = BUS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
        end else begin
            bus_state <= next_state;
        end
    end

    // waitrequest drops for exactly the answer cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= (next_state != BUS_ACK);
        end
    end

    // address decode and read mux
    // reserved bits read zero
    always_comb begin
        read_value = 32'h0000_0000;
        addr_hit   = 1'b1;
        case (avs_address)
            DEEP_GATE_OFFSET:  read_value = deep_sleep_clock_gate_1 & GATE_WRITE_MASK;
            RUN_GATE_OFFSET:   read_value = run_clock_gate_1 & GATE_WRITE_MASK;
            SLEEP_GATE_OFFSET: read_value = sleep_clock_gate_1 & GATE_WRITE_MASK;
            RUN_CONFIG_OFFSET: read_value = run_clock_config & CONFIG_WRITE_MASK;
            IRQ_STATUS_OFFSET: read_value = irq_status & IRQ_WRITE_MASK;
            IRQ_MASK_OFFSET:   read_value = irq_mask & IRQ_WRITE_MASK;
            default:           addr_hit   = 1'b0;
        endcase
    end

    // read data and response, captured as the answer is prepared
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= RESP_OKAY;
        end else if (bus_state == BUS_IDLE && (avs_read || avs_write)) begin
            avs_readdata <= avs_read ? read_value : 32'h0000_0000;
            avs_response <= addr_hit ? RESP_OKAY : RESP_DECODE_ERROR;
        end
    end

    // deep-sleep enable register
    // reset to all disabled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            deep_sleep_clock_gate_1 <= GATE_RESET;
        end else if (wr_commit && avs_address == DEEP_GATE_OFFSET) begin
            deep_sleep_clock_gate_1 <= merge_write(deep_sleep_clock_gate_1, avs_writedata,
                                                   avs_byteenable, GATE_WRITE_MASK);
        end
    end

    // run-mode companion enables
    // run layout companion
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_clock_gate_1 <= GATE_RESET;
        end else if (wr_commit && avs_address == RUN_GATE_OFFSET) begin
            run_clock_gate_1 <= merge_write(run_clock_gate_1, avs_writedata,
                                            avs_byteenable, GATE_WRITE_MASK);
        end
    end

    // sleep-mode companion enables
    // sleep layout companion
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sleep_clock_gate_1 <= GATE_RESET;
        end else if (wr_commit && avs_address == SLEEP_GATE_OFFSET) begin
            sleep_clock_gate_1 <= merge_write(sleep_clock_gate_1, avs_writedata,
                                              avs_byteenable, GATE_WRITE_MASK);
        end
    end

    // run clock configuration holding auto gating
    // auto gating bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_clock_config <= CONFIG_RESET;
        end else if (wr_commit && avs_address == RUN_CONFIG_OFFSET) begin
            run_clock_config <= merge_write(run_clock_config, avs_writedata,
                                            avs_byteenable, CONFIG_WRITE_MASK);
        end
    end

    // interrupt mask register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_commit && avs_address == IRQ_MASK_OFFSET) begin
            irq_mask <= merge_write(irq_mask, avs_writedata, avs_byteenable, IRQ_WRITE_MASK);
        end
    end

    // mode-dependent selection of the enable set
    // deep set in deep-sleep
    gate_select u_gate_select (
        .power_mode  (power_mode),
        .auto_gating (auto_clock_gating),
        .run_gate    (run_clock_gate_1),
        .sleep_gate  (sleep_clock_gate_1),
        .deep_gate   (deep_sleep_clock_gate_1),
        .selected    (selected),
        .deep_active (deep_active)
    );

    // registered enables drive the peripheral clock gates
    // enable drives clock gate
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clock_enable <= GATE_RESET;
        end else begin
            clock_enable <= selected & GATE_WRITE_MASK;
        end
    end

    // peripheral access check against the live enables
    // gated unit faults
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            periph_grant <= 1'b0;
            periph_fault <= 1'b0;
        end else begin
            periph_grant <= periph_req && clock_enable[periph_unit];
            periph_fault <= periph_req && !clock_enable[periph_unit];
        end
    end

    // deep-sleep entry edge detector
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            deep_active_q <= 1'b0;
        end else begin
            deep_active_q <= deep_active;
        end
    end

    // events and write-one-to-clear requests
    assign fault_event = periph_req && !clock_enable[periph_unit];
    assign deep_entry  = deep_active && !deep_active_q;
    assign irq_set     = ({31'h0, fault_event} << IRQ_FAULT_BIT) |
                         ({31'h0, deep_entry} << IRQ_DEEP_ENTRY_BIT);
    assign irq_clear   = (wr_commit && avs_address == IRQ_STATUS_OFFSET) ?
                         (avs_writedata & byte_mask(avs_byteenable) & IRQ_WRITE_MASK) :
                         32'h0000_0000;

    // sticky status, a new event wins over a clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask & IRQ_WRITE_MASK);
        end
    end

    // request seen while idle
    sequence seq_request;
        bus_state == BUS_IDLE && (avs_read || avs_write);
    endsequence

    // one answer cycle then waitrequest back high
    sequence seq_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    // every request answered after one wait cycle
    AST_BUS_ANSWER: assert property (@(posedge mclk) disable iff (rst)
        seq_request |=> seq_answer)
        else $error("bus answer not given in one cycle");

    // reserved bits of the deep register always read zero
    // reserved read zero
    AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst)
        bus_state == BUS_IDLE && avs_read && avs_address == DEEP_GATE_OFFSET
        |=> ((avs_readdata & ~GATE_WRITE_MASK) == 32'h0000_0000) && !avs_waitrequest)
        else $error("reserved bits read nonzero");

    // committed write updates only writable, enabled bits
    // masked write check
    AST_MASKED_WRITE: assert property (@(posedge mclk) disable iff (rst)
        wr_commit && avs_address == DEEP_GATE_OFFSET |=>
        deep_sleep_clock_gate_1 == merge_write($past(deep_sleep_clock_gate_1),
            $past(avs_writedata), $past(avs_byteenable), GATE_WRITE_MASK))
        else $error("deep register write merged wrongly");

    // reset clears enables and gates
    // reset value check
    AST_RESET_ZERO: assert property (@(posedge mclk)
        rst |=> deep_sleep_clock_gate_1 == GATE_RESET && clock_enable == GATE_RESET)
        else $error("enables not zero after reset");

    // deep-sleep with auto gating applies the deep set
    // deep set applied
    AST_DEEP_APPLIED: assert property (@(posedge mclk) disable iff (rst)
        auto_clock_gating && power_mode == MODE_DEEP |=>
        clock_enable == $past(deep_sleep_clock_gate_1))
        else $error("deep set not applied in deep-sleep");

    // without auto gating the run set stays in force
    // run set kept
    AST_RUN_KEPT: assert property (@(posedge mclk) disable iff (rst)
        !auto_clock_gating |=> clock_enable == $past(run_clock_gate_1))
        else $error("run set not in force without auto gating");

    // enabled unit is granted, never faulted
    // clocked unit granted
    AST_GRANT: assert property (@(posedge mclk) disable iff (rst)
        periph_req && clock_enable[periph_unit] |=> periph_grant && !periph_fault)
        else $error("enabled unit not granted");

    // gated unit is faulted, never granted
    // gated unit faulted
    AST_FAULT: assert property (@(posedge mclk) disable iff (rst)
        periph_req && !clock_enable[periph_unit] |=> periph_fault && !periph_grant)
        else $error("gated unit access not faulted");

    // fault event is recorded even against a clear
    AST_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
        fault_event |=> irq_status[IRQ_FAULT_BIT] ##1
        irq == ($past(irq_mask[IRQ_FAULT_BIT]) ||
                $past(irq_status[IRQ_DEEP_ENTRY_BIT] && irq_mask[IRQ_DEEP_ENTRY_BIT])))
        else $error("fault event lost or interrupt wrong");

    // no interrupt without an unmasked status bit
    AST_IRQ_QUIET: assert property (@(posedge mclk) disable iff (rst)
        (irq_status & irq_mask) == 32'h0000_0000 |=> !irq)
        else $error("interrupt without unmasked status");

    // sleep with auto gating applies the sleep set
    // sleep set applied
    AST_SLEEP_APPLIED: assert property (@(posedge mclk) disable iff (rst)
        auto_clock_gating && power_mode == MODE_SLEEP |=>
        clock_enable == $past(sleep_clock_gate_1))
        else $error("sleep set not applied in sleep");

    // entering deep-sleep with auto gating raises the entry status bit
    // deep entry recorded
    AST_DEEP_ENTRY: assert property (@(posedge mclk) disable iff (rst)
        deep_active && !deep_active_q |=> irq_status[IRQ_DEEP_ENTRY_BIT])
        else $error("deep-sleep entry not recorded");

    // unmapped address answers a decode error and no data
    AST_UNMAPPED_ERROR: assert property (@(posedge mclk) disable iff (rst)
        bus_state == BUS_IDLE && (avs_read || avs_write) && !addr_hit |=>
        avs_response == RESP_DECODE_ERROR && avs_readdata == 32'h0000_0000)
        else $error("unmapped access not answered with decode error");

    // a clear with no new fault empties the fault bit
    AST_STATUS_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        irq_clear[IRQ_FAULT_BIT] && !fault_event |=> !irq_status[IRQ_FAULT_BIT])
        else $error("fault status not cleared");

    // reserved positions never enable a clock
    // reserved enables zero
    AST_ENABLE_RESERVED: assert property (@(posedge mclk) disable iff (rst)
        (clock_enable & ~GATE_WRITE_MASK) == 32'h0000_0000)
        else $error("reserved enable bit set");

endmodule : deep_sleep_clock_gating_reg1
`default_nettype wire

//--- tb/gate_partner.sv
`timescale 1ns/1ps
`default_nettype none
module gate_partner (
    input  wire logic                           mclk,
    input  wire logic                           periph_grant,
    input  wire logic                           periph_fault,
    output var  clock_gate_pkg::power_mode_type power_mode,
    output var  logic                           periph_req,
    output var  logic [4:0]                     periph_unit
);
    import clock_gate_pkg::*;

    // idle levels at time zero
    initial begin
        power_mode  = MODE_RUN;
        periph_req  = 1'b0;
        periph_unit = 5'h00;
    end

    // power controller moves the mode just after an edge
    task automatic set_mode(input power_mode_type m);
        @(posedge mclk);
        power_mode <= m;
    endtask : set_mode

    task automatic access(input logic [4:0] u, output logic g, output logic f);
        @(posedge mclk);
        periph_req  <= 1'b1;
        periph_unit <= u;
        @(posedge mclk);
        periph_req  <= 1'b0;
        periph_unit <= ~u; // no stale unit once released
        #1;
        g = periph_grant;
        f = periph_fault;
    endtask : access
endmodule : gate_partner
`default_nettype wire

//--- tb/tb_deep_sleep_clock_gating_reg1.sv
`timescale 1ns/1ps
`default_nettype none
module tb_deep_sleep_clock_gating_reg1;
    import clock_gate_pkg::*;
    localparam logic [31:0] WMASK = 32'h030F_5037;
    logic                 mclk;
    logic                 rst;
    logic [11:0]          avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [1:0]           avs_response;
    power_mode_type       power_mode;
    logic [31:0]          clock_enable;
    logic                 periph_req;
    logic [4:0]           periph_unit;
    logic                 periph_grant;
    logic                 periph_fault;
    logic                 irq;
    logic [31:0]          gm [3];
    logic [11:0]          ga [3];
    logic [31:0]          rd;
    logic [31:0]          d;
    logic [3:0]           be;
    logic [1:0]           resp;
    logic                 g;
    logic                 f;
    logic                 auto_m;
    int                   failures;
    int                   comparisons;
    int                   cycles;
    int                   seed;
    int                   modes [4] = '{0, 1, 3, 2};

    deep_sleep_clock_gating_reg1 uut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .power_mode(power_mode), .clock_enable(clock_enable), .periph_req(periph_req),
        .periph_unit(periph_unit), .periph_grant(periph_grant),
        .periph_fault(periph_fault), .irq(irq));

    gate_partner partner (.mclk(mclk), .periph_grant(periph_grant),
        .periph_fault(periph_fault), .power_mode(power_mode), .periph_req(periph_req),
        .periph_unit(periph_unit));

    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    // avalon transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] b);
        @(posedge mclk);
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_address    <= a;
        avs_writedata  <= wd;
        avs_byteenable <= b;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        resp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic read_check(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, $random(seed), 4'hF);
        check_word(what, exp, rd);
        check_word("response", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : read_check

    // model of a masked byte-lane write
    function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] b, input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wm;
        upd = (old & ~m) | (wd & m);
    endfunction : upd

    // model of the enable selection
    function automatic logic [31:0] pick(input int m);
        if (auto_m && m == 1) pick = gm[2];
        else if (auto_m && m == 3) pick = gm[0];
        else pick = gm[1];
    endfunction : pick

    initial begin
        seed = 67070;
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        ga = '{DEEP_GATE_OFFSET, RUN_GATE_OFFSET, SLEEP_GATE_OFFSET};
        gm = '{32'h0, 32'h0, 32'h0};
        auto_m = 1'b0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        // reset values
        for (int k = 0; k < 3; k++) read_check(ga[k], 32'h0, "gate reset");
        read_check(RUN_CONFIG_OFFSET, 32'h0, "config reset");
        read_check(IRQ_STATUS_OFFSET, 32'h0, "status reset");
        read_check(IRQ_MASK_OFFSET, 32'h0, "mask reset");
        check_word("enable reset", 32'h0, clock_enable);
        $display("test reset done");
        // random writes with byte lanes, reserved bits ignored
        for (int i = 0; i < 16; i++) begin
            d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            be = (i == 0) ? 4'hF : 4'($random(seed));
            for (int k = 0; k < 3; k++) begin
                bus(1'b1, ga[k], d, be);
                gm[k] = upd(gm[k], d, be, WMASK);
                read_check(ga[k], gm[k], "gate readback");
            end
        end
        bus(1'b0, DEEP_GATE_OFFSET, 32'h0, 4'hF);
        bus(1'b1, DEEP_GATE_OFFSET, rd ^ 32'h0000_0001, 4'hF);
        gm[0] = gm[0] ^ 32'h0000_0001;
        read_check(DEEP_GATE_OFFSET, gm[0], "rmw readback");
        // unmapped place: no data, decode error, no side effect
        bus(1'b1, 12'h300, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 12'hFFC, 32'h0, 4'hF);
        check_word("unmapped data", 32'h0, rd);
        check_word("unmapped resp", {30'h0, RESP_DECODE_ERROR}, {30'h0, resp});
        read_check(DEEP_GATE_OFFSET, gm[0], "after unmapped");
        $display("test registers done");
        // every mode with and without auto gating
        for (int a = 0; a < 2; a++) begin
            auto_m = a[0];
            bus(1'b1, RUN_CONFIG_OFFSET, {31'h0, auto_m}, 4'hF);
            for (int j = 0; j < 4; j++) begin
                partner.set_mode(power_mode_type'(modes[j][1:0]));
                repeat (3) @(posedge mclk);
                check_word("clock enable", pick(modes[j]), clock_enable);
            end
        end
        $display("test selection done");
        // accesses to every unit position in deep-sleep
        bus(1'b1, DEEP_GATE_OFFSET, 32'h0305_1025, 4'hF);
        gm[0] = 32'h0305_1025;
        partner.set_mode(MODE_DEEP);
        repeat (3) @(posedge mclk);
        for (int u = 0; u < 32; u++) begin
            partner.access(5'(u), g, f);
            check_word("grant", {31'h0, gm[0][u]}, {31'h0, g});
            check_word("fault", {31'h0, !gm[0][u]}, {31'h0, f});
        end
        $display("test access done");
        // interrupt raise, mask and clear
        partner.set_mode(MODE_RUN);
        bus(1'b1, IRQ_MASK_OFFSET, 32'h0, 4'hF);
        bus(1'b1, IRQ_STATUS_OFFSET, 32'h3, 4'hF);
        read_check(IRQ_STATUS_OFFSET, 32'h0, "status cleared");
        partner.access(5'd3, g, f);
        read_check(IRQ_STATUS_OFFSET, 32'h1, "fault status");
        check_word("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, IRQ_MASK_OFFSET, 32'h1, 4'hF);
        repeat (2) @(posedge mclk);
        check_word("irq set", 32'h1, {31'h0, irq});
        bus(1'b1, IRQ_STATUS_OFFSET, 32'h1, 4'hF);
        repeat (2) @(posedge mclk);
        check_word("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b1, IRQ_MASK_OFFSET, 32'hFFFF_FFFF, 4'hF);
        read_check(IRQ_MASK_OFFSET, 32'h3, "mask readback");
        partner.set_mode(MODE_DEEP);
        repeat (3) @(posedge mclk);
        check_word("irq entry", 32'h1, {31'h0, irq});
        read_check(IRQ_STATUS_OFFSET, 32'h2, "entry status");
        bus(1'b1, IRQ_STATUS_OFFSET, 32'h2, 4'hF);
        repeat (2) @(posedge mclk);
        check_word("irq entry clear", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        end_of_test();
    end
endmodule : tb_deep_sleep_clock_gating_reg1
`default_nettype wire
